// ==== design/ubst_ctrl.sv ====
// Operation
// - Any low enable bit drives interrupt request
// - All low enables zero: poll line status
// - Sleep allowed only with enhanced and sleep bits
// - Sleep needs idle rx, empty tx, no irq other than transmit-empty
// - Never sleep with receive FIFO data
// - Asleep: UART clock gated off
// - Wake on rx edge, modem change, transmit holding write
// - Time-out four character times after last
// - Restart time-out at stop middle, FIFO read
// - Break: rx low beyond one full frame
// - Break bit holds transmit output low
// - Sixteen-bit divisor, one to 65535
// - Divide-by-four prescaler when clock-divisor bit set
// - Prescaler divides by one after reset
// - Generator output is sixteen times baud
// - Divisor low byte 7:0, high 15:8
// - Zero divisor generates no baud clock
// - One generator times transmit and receive
// - Divisor reachable only with latch enable
// - Resets leave divisor bytes unchanged
module ubst_ctrl
  import ubst_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial and modem pins
  input  wire logic        rx_pin,
  input  wire logic [3:0]  modem_in,
  output logic             tx_pin,
  output logic             irq_n,
  // UART datapath, same clock
  input  wire logic        tx_serial,
  input  wire logic        tx_fifo_empty,
  input  wire logic        tx_shift_empty,
  input  wire logic        rx_fifo_empty,
  input  wire logic        rx_below_trigger,
  input  wire logic        rx_stop_mid,
  input  wire logic        rx_data_irq,
  input  wire logic        rx_line_err,
  input  wire logic [7:0]  rx_fifo_rdata,
  output logic             rx_fifo_rd,
  output logic             tx_fifo_wr,
  output logic [7:0]       tx_fifo_wdata,
  output logic             baud16_tick,
  output logic             uart_clk_run
);

  // Address index shared by both channels; upper bits unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    reg_index = addr[4:2];
  endfunction : reg_index

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr[7:5] == 3'h0);
  endfunction : addr_mapped

  // Registers
  logic [7:0]  int_enable_reg;
  logic [7:0]  line_control_reg;
  logic [7:0]  modem_control_reg;
  logic [7:0]  enhanced_feature_reg;
  logic [7:0]  scratch_reg;
  logic [7:0]  divisor_low_byte;
  logic [7:0]  divisor_high_byte;
  logic [15:0] divisor;

  // Bus state
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        wr_fire;
  logic        rd_fire;
  logic [2:0]  wr_idx;
  logic [2:0]  rd_idx;
  logic        dlab;
  logic        efr_open;

  // Pin synchronisers: rx on bit 4, modem inputs on 3:0
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic [4:0]  sync3;
  logic [4:0]  pin_filt;
  logic [4:0]  pin_prev;
  logic [4:0]  pin_edge;
  logic [3:0]  modem_delta;

  // Timing
  logic [CNT_W-1:0] char_ticks;
  logic [CNT_W-1:0] timeout_ticks;
  logic [CNT_W-1:0] tout_cnt;
  logic [CNT_W-1:0] idle_cnt;
  logic [CNT_W-1:0] brk_cnt;
  logic             timeout_flag;
  logic             rx_idle;
  logic             break_flag;
  logic             thr_write;

  // Sleep and interrupt
  ubst_sleep_t      sleep_state;
  ubst_sleep_t      next_sleep_state;
  logic             sleep_allowed;
  logic             sleep_ready;
  logic             wake_event;
  logic             irq_other;
  logic             irq_thr;
  logic [7:0]       line_status_reg;

  assign dlab      = line_control_reg[LCR_DLAB_BIT];
  assign efr_open  = (line_control_reg == EFR_ACCESS_KEY);
  assign wr_idx    = reg_index(aw_addr);
  assign rd_idx    = reg_index(araddr);
  assign wr_fire   = aw_held && w_held && !bvalid;
  assign rd_fire   = arvalid && arready;
  assign awready   = !aw_held && !bvalid;
  assign wready    = !w_held && !bvalid;
  assign arready   = !rvalid;
  assign divisor   = {divisor_high_byte, divisor_low_byte};
  assign thr_write = wr_fire && w_lane0 && addr_mapped(aw_addr) && !dlab
                     && (wr_idx == REG_DATA_IDX);

  // Write address and data are taken independently and held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control registers under reset; prescaler select clears to divide-by-one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_enable_reg       <= IER_RESET;
      line_control_reg     <= LCR_RESET;
      modem_control_reg    <= MCR_RESET;
      enhanced_feature_reg <= EFR_RESET;
      scratch_reg          <= SPR_RESET;
    end else if (wr_fire && w_lane0 && addr_mapped(aw_addr)) begin
      case (wr_idx)
        REG_IER_IDX: begin
          if (!dlab) begin
            int_enable_reg <= w_byte;
          end
        end
        REG_IIR_IDX: begin
          if (efr_open) begin
            enhanced_feature_reg <= w_byte;
          end
        end
        REG_LCR_IDX: line_control_reg <= w_byte;
        REG_MCR_IDX: begin
          // Clock-divisor bit is writable only with enhanced functions on
          modem_control_reg[6:0] <= w_byte[6:0];
          if (enhanced_feature_reg[EFR_ENH_BIT]) begin
            modem_control_reg[MCR_CLKDIV_BIT] <= w_byte[MCR_CLKDIV_BIT];
          end
        end
        REG_SPR_IDX: scratch_reg <= w_byte;
        default: ;
      endcase
    end
  end

  // Divisor bytes: no reset, reached only with the latch enable set;
  // writes while asleep are accepted, the host is expected to avoid them
  always_ff @(posedge aclk) begin
    if (wr_fire && w_lane0 && addr_mapped(aw_addr) && dlab) begin
      if (wr_idx == REG_DIVLO_IDX) begin
        divisor_low_byte <= w_byte;
      end
      if (wr_idx == REG_DIVHI_IDX) begin
        divisor_high_byte <= w_byte;
      end
    end
  end

  // Transmit holding slot write and receive FIFO read strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_fifo_wr    <= 1'b0;
      tx_fifo_wdata <= 8'h00;
      rx_fifo_rd    <= 1'b0;
    end else begin
      tx_fifo_wr    <= thr_write;
      tx_fifo_wdata <= thr_write ? w_byte : tx_fifo_wdata;
      rx_fifo_rd    <= rd_fire && addr_mapped(araddr) && !dlab && (rd_idx == REG_DATA_IDX);
    end
  end

  // Line status as the host polls it
  always_comb begin
    line_status_reg               = 8'h00;
    line_status_reg[LSR_DR_BIT]   = !rx_fifo_empty;
    line_status_reg[LSR_BRK_BIT]  = break_flag;
    line_status_reg[LSR_THRE_BIT] = tx_fifo_empty;
    line_status_reg[LSR_TEMT_BIT] = tx_fifo_empty && tx_shift_empty;
  end

  // Read data path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rresp  <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata  <= 32'h0000_0000;
      if (addr_mapped(araddr)) begin
        case (rd_idx)
          REG_DATA_IDX: rdata[7:0] <= dlab ? divisor_low_byte : rx_fifo_rdata;
          REG_IER_IDX:  rdata[7:0] <= dlab ? divisor_high_byte : int_enable_reg;
          REG_IIR_IDX:  rdata[7:0] <= efr_open ? enhanced_feature_reg : {7'h00, irq_n};
          REG_LCR_IDX:  rdata[7:0] <= line_control_reg;
          REG_MCR_IDX:  rdata[7:0] <= modem_control_reg;
          REG_LSR_IDX:  rdata[7:0] <= line_status_reg;
          REG_MSR_IDX:  rdata[7:0] <= {pin_filt[3:0], modem_delta};
          REG_SPR_IDX:  rdata[7:0] <= scratch_reg;
          default:      rdata[7:0] <= 8'h00;
        endcase
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Three-stage pin synchronisers; a change counts when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1[gi]    <= 1'b1;
          sync2[gi]    <= 1'b1;
          sync3[gi]    <= 1'b1;
          pin_filt[gi] <= 1'b1;
          pin_prev[gi] <= 1'b1;
        end else begin
          sync1[gi]    <= (gi == 4) ? rx_pin : modem_in[gi];
          sync2[gi]    <= sync1[gi];
          sync3[gi]    <= sync2[gi];
          pin_filt[gi] <= (sync2[gi] == sync3[gi]) ? sync3[gi] : pin_filt[gi];
          pin_prev[gi] <= pin_filt[gi];
        end
      end
      assign pin_edge[gi] = pin_filt[gi] ^ pin_prev[gi];
    end
  endgenerate

  // Modem change flags; a change in the read cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_delta <= 4'h0;
    end else if (rd_fire && addr_mapped(araddr) && (rd_idx == REG_MSR_IDX)) begin
      modem_delta <= pin_edge[3:0];
    end else begin
      modem_delta <= modem_delta | pin_edge[3:0];
    end
  end

  // Frame and time-out lengths in sixteen-times ticks
  always_comb begin
    char_ticks = CNT_W'((32'd7 + 32'(line_control_reg[1:0])
                 + 32'(line_control_reg[LCR_PAR_BIT]) + 32'(line_control_reg[LCR_STOP_BIT]))
                 * TICKS_PER_BIT);
    timeout_ticks = CNT_W'(32'(char_ticks) * TIMEOUT_CHARS);
  end

  // Receive time-out counter, restarted at stop middle and FIFO reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tout_cnt     <= '0;
      timeout_flag <= 1'b0;
    end else begin
      if (rx_stop_mid || rx_fifo_rd || rx_fifo_empty) begin
        tout_cnt <= '0;
      end else if (baud16_tick && tout_cnt < timeout_ticks) begin
        tout_cnt <= tout_cnt + CNT_W'(1);
      end
      if (!rx_fifo_empty && rx_below_trigger && tout_cnt == timeout_ticks) begin
        timeout_flag <= 1'b1;
      end else if (rx_fifo_rd || rx_stop_mid || rx_fifo_empty) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // Receive line idle once a whole time-out window passes without an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt <= '0;
      rx_idle  <= 1'b0;
    end else if (pin_edge[4]) begin
      idle_cnt <= '0;
      rx_idle  <= 1'b0;
    end else if (baud16_tick && idle_cnt < timeout_ticks) begin
      idle_cnt <= idle_cnt + CNT_W'(1);
    end else if (idle_cnt == timeout_ticks) begin
      rx_idle <= 1'b1;
    end
  end

  // Break detection: line low for longer than a full frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_cnt    <= '0;
      break_flag <= 1'b0;
    end else begin
      if (pin_filt[4]) begin
        brk_cnt <= '0;
      end else if (baud16_tick && brk_cnt <= char_ticks) begin
        brk_cnt <= brk_cnt + CNT_W'(1);
      end
      if (!pin_filt[4] && brk_cnt > char_ticks) begin
        break_flag <= 1'b1;
      end else if (rd_fire && addr_mapped(araddr) && (rd_idx == REG_LSR_IDX)) begin
        break_flag <= 1'b0;
      end
    end
  end

  // Interrupt sources gated by the four low enables
  assign irq_thr   = int_enable_reg[IER_THR_BIT] && tx_fifo_empty;
  assign irq_other = (int_enable_reg[IER_RX_BIT] && (rx_data_irq || timeout_flag))
                   || (int_enable_reg[IER_LINE_BIT] && (rx_line_err || break_flag))
                   || (int_enable_reg[IER_MODEM_BIT] && (modem_delta != 4'h0));

  // Interrupt request pin; stays inactive in polled mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(irq_other || irq_thr);
    end
  end

  // Sleep entry and wake conditions
  assign sleep_allowed = enhanced_feature_reg[EFR_ENH_BIT]
                       && int_enable_reg[IER_SLEEP_BIT];
  assign sleep_ready   = rx_idle && tx_fifo_empty && tx_shift_empty
                       && !irq_other && rx_fifo_empty && !tx_fifo_wr;
  assign wake_event    = (pin_edge != 5'h00) || thr_write;

  always_comb begin
    case (sleep_state)
      SLP_AWAKE: begin
        next_sleep_state = (sleep_allowed && sleep_ready && !wake_event)
                           ? SLP_ASLEEP : SLP_AWAKE;
      end
      SLP_ASLEEP: begin
        next_sleep_state = (wake_event || !sleep_allowed || !rx_fifo_empty)
                           ? SLP_AWAKE : SLP_ASLEEP;
      end
      default: next_sleep_state = SLP_AWAKE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_state <= SLP_AWAKE;
    end else begin
      sleep_state <= next_sleep_state;
    end
  end

  // UART clock gate; baud ticks stop and timing counters freeze
  assign uart_clk_run = (sleep_state == SLP_AWAKE);

  // Break forces the transmit output low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= line_control_reg[LCR_BREAK_BIT] ? 1'b0 : tx_serial;
    end
  end

  // Single baud generator for both directions
  ubst_baud_gen u_baud (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (uart_clk_run),
    .prescale4 (modem_control_reg[MCR_CLKDIV_BIT]),
    .divisor   (divisor),
    .tick      (baud16_tick)
  );

endmodule : ubst_ctrl

// ==== design/ubst_pkg.sv ====
package ubst_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] REG_DATA_IDX   = 3'h0;  // receive read / transmit holding slot write
  localparam logic [2:0] REG_IER_IDX    = 3'h1;  // int_enable_reg
  localparam logic [2:0] REG_IIR_IDX    = 3'h2;  // interrupt ident read, or enhanced_feature_reg
  localparam logic [2:0] REG_LCR_IDX    = 3'h3;  // line_control_reg
  localparam logic [2:0] REG_MCR_IDX    = 3'h4;  // modem_control_reg
  localparam logic [2:0] REG_LSR_IDX    = 3'h5;  // line_status_reg
  localparam logic [2:0] REG_MSR_IDX    = 3'h6;  // modem status
  localparam logic [2:0] REG_SPR_IDX    = 3'h7;  // scratch
  localparam logic [2:0] REG_DIVLO_IDX  = 3'h0;  // divisor low byte, latch enabled
  localparam logic [2:0] REG_DIVHI_IDX  = 3'h1;  // divisor_high_byte, latch enabled

  // Values after reset
  localparam logic [7:0] IER_RESET      = 8'h00;
  localparam logic [7:0] LCR_RESET      = 8'h1D;
  localparam logic [7:0] MCR_RESET      = 8'h00;
  localparam logic [7:0] EFR_RESET      = 8'h00;
  localparam logic [7:0] SPR_RESET      = 8'h00;

  // Field positions
  localparam int IER_RX_BIT     = 0;
  localparam int IER_THR_BIT    = 1;
  localparam int IER_LINE_BIT   = 2;
  localparam int IER_MODEM_BIT  = 3;
  localparam int IER_SLEEP_BIT  = 4;
  localparam int EFR_ENH_BIT    = 4;
  localparam int LCR_DLAB_BIT   = 7;
  localparam int LCR_BREAK_BIT  = 6;
  localparam int LCR_PAR_BIT    = 3;
  localparam int LCR_STOP_BIT   = 2;
  localparam int MCR_CLKDIV_BIT = 7;
  localparam int LSR_DR_BIT     = 0;
  localparam int LSR_BRK_BIT    = 4;
  localparam int LSR_THRE_BIT   = 5;
  localparam int LSR_TEMT_BIT   = 6;

  // Enhanced register window key
  localparam logic [7:0] EFR_ACCESS_KEY = 8'hBF;

  // Timing in baud ticks and clock cycles
  localparam int         TICKS_PER_BIT  = 16;
  localparam int         TIMEOUT_CHARS  = 4;
  localparam logic [1:0] PRESCALE_LAST  = 2'h3;  // divide-by-4 prescaler
  localparam int         CNT_W          = 12;

  // AXI responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Sleep controller states
  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b01,
    SLP_ASLEEP = 2'b10
  } ubst_sleep_t;

endpackage : ubst_pkg

// ==== design/ubst_baud_gen.sv ====
module ubst_baud_gen
  import ubst_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic        run,
  input  wire logic        prescale4,
  input  wire logic [15:0] divisor,
  // Sixteen-times baud tick
  output logic             tick
);

  logic [1:0]  pre_cnt;
  logic        pre_tick;
  logic [15:0] div_cnt;

  // Optional divide-by-4 prescaler ahead of the divisor
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || !prescale4) begin
      pre_cnt <= 2'h0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end

  assign pre_tick = prescale4 ? (pre_cnt == PRESCALE_LAST) : 1'b1;

  // Divisor counter; a zero divisor yields no tick at all
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (divisor == 16'h0000) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (pre_tick) begin
      if (div_cnt >= divisor - 16'h0001) begin
        div_cnt <= 16'h0000;
        tick    <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
        tick    <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule : ubst_baud_gen

// ==== sim/ubst_ctrl_assertions.sv ====
module ubst_ctrl_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  // Pins
  input wire logic        rx_pin,
  input wire logic [3:0]  modem_in,
  input wire logic        tx_pin,
  // Datapath
  input wire logic        tx_serial,
  input wire logic        tx_fifo_empty,
  input wire logic        tx_shift_empty,
  input wire logic        rx_fifo_empty,
  input wire logic        rx_fifo_rd,
  input wire logic        tx_fifo_wr,
  input wire logic        baud16_tick,
  input wire logic        uart_clk_run
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Break output
  property p_tx_brk; tx_pin |-> $past(tx_serial); endproperty
  a_tx_brk: assert property (p_tx_brk) else $error("break");
  // Bus handshake
  property p_b_busy; bvalid |-> !awready && !wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("bus busy");
  property p_b_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_b_done: assert property (p_b_done) else $error("b stuck");
  property p_ar_ans; arvalid && arready |=> rvalid && rdata[31:8] == 24'h0; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer");
  // FIFO read strobe
  property p_rd_pulse; rx_fifo_rd |-> $past(arvalid && arready) ##1 !rx_fifo_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd strobe");
  // Sleep
  property p_slp_tick; !uart_clk_run && $past(!uart_clk_run) |-> !baud16_tick; endproperty
  a_slp_tick: assert property (p_slp_tick) else $error("tick while asleep");
  property p_slp_entry;
    $fell(uart_clk_run) |-> $past(rx_fifo_empty && tx_fifo_empty && tx_shift_empty);
  endproperty
  a_slp_entry: assert property (p_slp_entry) else $error("slept while busy");
  property p_awake_fifo; !rx_fifo_empty [*3] |-> uart_clk_run; endproperty
  a_awake_fifo: assert property (p_awake_fifo) else $error("asleep with rx data");
  property p_wake_pin; $changed(rx_pin) || $changed(modem_in) |-> ##[1:8] uart_clk_run; endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("pin wake");
  property p_wake_tx; tx_fifo_wr |-> ##[0:2] uart_clk_run; endproperty
  a_wake_tx: assert property (p_wake_tx) else $error("tx wake");
  // Covers
  c_wr: cover property (bvalid && bready);
  c_rd: cover property (rvalid);
  c_slp: cover property ($fell(uart_clk_run));
  c_tick: cover property (baud16_tick);
endmodule : ubst_ctrl_chk

// ==== sim/ubst_line_model.sv ====
module ubst_line_model (
  // Clock
  input wire logic  aclk,
  // Remote line device outputs
  output logic       rx_pin,
  output logic [3:0] modem_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels, all high
  initial begin
    rx_pin = 1'h1;
    modem_in = 4'hF;
  end
  // Line low for n cycles
  task automatic hold_low(input int n);
    @(posedge aclk);
    rx_pin <= 1'h0;
    repeat (n) @(posedge aclk);
    rx_pin <= 1'h1;
  endtask : hold_low
  // Flip a modem pin
  task automatic flip_modem(input int b);
    @(posedge aclk);
    modem_in[b] <= ~modem_in[b];
  endtask : flip_modem
endmodule : ubst_line_model

// ==== sim/uart_baud_sleep_timeout_ctrl_tb_top.sv ====
module uart_baud_sleep_timeout_ctrl_tb_top
  import ubst_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [1:0] r;} ubst_row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, rx_pin, tx_pin, irq_n, tx_serial, tx_fifo_empty;
  logic        tx_shift_empty, rx_fifo_empty, rx_below_trigger, rx_stop_mid, rx_data_irq;
  logic        rx_line_err, rx_fifo_rd, tx_fifo_wr, baud16_tick, uart_clk_run;
  logic [7:0]  awaddr, araddr, rx_fifo_rdata, tx_fifo_wdata, txd;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, modem_in;
  logic [1:0]  bresp, rresp;
  int          checks, mismatches, t, s;
  ubst_row_t   rows [11] = '{
    '{1'h0, 8'h0C, LCR_RESET, RESP_OKAY},
    '{1'h0, 8'h04, IER_RESET, RESP_OKAY},
    '{1'h0, 8'h10, MCR_RESET, RESP_OKAY},
    '{1'h0, 8'h14, 8'h60, RESP_OKAY},
    '{1'h0, 8'h00, 8'hA5, RESP_OKAY},
    '{1'h1, 8'h1C, 8'h5A, RESP_OKAY},
    '{1'h0, 8'h1C, 8'h5A, RESP_OKAY},
    '{1'h1, 8'h10, 8'h80, RESP_OKAY},
    '{1'h0, 8'h10, 8'h00, RESP_OKAY},
    '{1'h1, 8'h20, 8'h11, RESP_SLVERR},
    '{1'h0, 8'h20, 8'h00, RESP_SLVERR}};

  ubst_ctrl dut_u (.*);
  ubst_line_model line_u (.aclk, .rx_pin, .modem_in);

  // Clock
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  // TX FIFO model
  always @(posedge aclk) begin
    if (tx_fifo_wr === 1'h1) begin
      txd <= tx_fifo_wdata;
      tx_fifo_empty <= 1'h0;
    end
  end

  // Compare and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic hang;
    chk(32'h0, 32'h1);
    results();
  endtask : hang
  task automatic settle(input int n);
    repeat (n) @(negedge aclk);
  endtask : settle
  // Bus write
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    logic ta, tw, got;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    got = 1'h0;
    for (n = 0; n < 40 && !got; n++) begin
      @(negedge aclk);
      {ta, tw, got, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    if (!got) hang();
    chk(32'(r), 32'(e));
  endtask : wr
  // Bus read
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    logic ta, got;
    logic [31:0] v;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    got = 1'h0;
    for (n = 0; n < 40 && !got; n++) begin
      @(negedge aclk);
      {ta, got, v, r} = {arvalid & arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    if (!got) hang();
    chk(v, {24'h0, d});
    chk(32'(r), 32'(e));
  endtask : rd
  // Tick period
  task automatic per(input logic [31:0] e);
    int n;
    for (n = 0; baud16_tick !== 1'h1; n++) begin
      if (n > 3000) hang();
      @(negedge aclk);
    end
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (baud16_tick !== 1'h1 && n < 3000);
    chk(n, e);
  endtask : per
  // Tick and sleep counts
  task automatic cnt(input int n);
    t = 0;
    s = 0;
    repeat (n) begin
      @(negedge aclk);
      t += int'(baud16_tick === 1'h1);
      s += int'(uart_clk_run !== 1'h1);
    end
  endtask : cnt
  // Wait for sleep state
  task automatic slp(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && uart_clk_run !== v; n++) @(negedge aclk);
    chk(32'(uart_clk_run), 32'(v));
    if (uart_clk_run !== v) results();
  endtask : slp

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_line_err} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {rx_below_trigger, rx_stop_mid, rx_data_irq} = 3'h0;
    {tx_serial, tx_fifo_empty, tx_shift_empty, rx_fifo_empty} = 4'hF;
    wstrb = 4'hF;
    rx_fifo_rdata = 8'hA5;
    checks = 0;
    mismatches = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
      else rd(rows[i].a, rows[i].d, rows[i].r);
    end
    $display("register table done");
    wr(8'h0C, 8'h83, RESP_OKAY);
    wr(8'h00, 8'h05, RESP_OKAY);
    wr(8'h04, 8'h00, RESP_OKAY);
    wr(8'h0C, 8'h03, RESP_OKAY);
    per(5);
    wr(8'h00, 8'hC3, RESP_OKAY);
    @(posedge aclk);
    tx_fifo_empty <= 1'h1;
    chk(txd, 8'hC3);
    per(5);
    wr(8'h0C, 8'hBF, RESP_OKAY);
    wr(8'h08, 8'h10, RESP_OKAY);
    wr(8'h0C, 8'h03, RESP_OKAY);
    wr(8'h10, 8'h80, RESP_OKAY);
    per(20);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    per(5);
    wr(8'h0C, 8'h83, RESP_OKAY);
    wr(8'h00, 8'h02, RESP_OKAY);
    wr(8'h04, 8'h01, RESP_OKAY);
    per(258);
    wr(8'h04, 8'h00, RESP_OKAY);
    wr(8'h00, 8'h00, RESP_OKAY);
    cnt(300);
    chk(t, 0);
    wr(8'h00, 8'h01, RESP_OKAY);
    per(1);
    wr(8'h0C, 8'h43, RESP_OKAY);
    settle(3);
    chk(32'(tx_pin), 0);
    wr(8'h0C, 8'h03, RESP_OKAY);
    settle(3);
    chk(32'(tx_pin), 1);
    $display("baud done");
    rx_data_irq <= 1'h1;
    settle(4);
    chk(32'(irq_n), 1);
    rd(8'h14, 8'h60, RESP_OKAY);
    wr(8'h04, 8'h01, RESP_OKAY);
    settle(3);
    chk(32'(irq_n), 0);
    rd(8'h08, 8'h00, RESP_OKAY);
    rx_data_irq <= 1'h0;
    line_u.hold_low(150);
    settle(10);
    rd(8'h14, 8'h60, RESP_OKAY);
    line_u.hold_low(200);
    settle(10);
    rd(8'h14, 8'h70, RESP_OKAY);
    rd(8'h14, 8'h60, RESP_OKAY);
    $display("irq and break done");
    @(posedge aclk);
    rx_below_trigger <= 1'h1;
    rx_fifo_empty <= 1'h0;
    settle(300);
    @(posedge aclk);
    rx_stop_mid <= 1'h1;
    @(posedge aclk);
    rx_stop_mid <= 1'h0;
    settle(600);
    chk(32'(irq_n), 1);
    settle(100);
    chk(32'(irq_n), 0);
    @(posedge aclk);
    rx_fifo_empty <= 1'h1;
    rx_below_trigger <= 1'h0;
    wr(8'h04, 8'h00, RESP_OKAY);
    $display("time-out done");
    wr(8'h0C, 8'hBF, RESP_OKAY);
    wr(8'h08, 8'h10, RESP_OKAY);
    wr(8'h0C, 8'h03, RESP_OKAY);
    cnt(1500);
    chk(s, 0);
    wr(8'h04, 8'h10, RESP_OKAY);
    slp(1'h0, 3000);
    cnt(50);
    chk(t, 0);
    line_u.flip_modem(2);
    slp(1'h1, 10);
    @(posedge aclk);
    rx_fifo_empty <= 1'h0;
    settle(2);
    cnt(1000);
    chk(s, 0);
    @(posedge aclk);
    rx_fifo_empty <= 1'h1;
    slp(1'h0, 3000);
    wr(8'h00, 8'h33, RESP_OKAY);
    settle(2);
    chk(32'(uart_clk_run), 1);
    @(posedge aclk);
    tx_fifo_empty <= 1'h1;
    slp(1'h0, 3000);
    line_u.hold_low(2);
    slp(1'h1, 10);
    wr(8'h04, 8'h00, RESP_OKAY);
    $display("sleep done");
    results();
  end
endmodule : uart_baud_sleep_timeout_ctrl_tb_top

bind ubst_ctrl ubst_ctrl_chk chk_u (.*);
